// ==== hw/ochc_top.sv ====
// overcurrent sample, monitoring window and hiccup sequencer
`timescale 1ns/1ps
`include "ochc_consts.svh"
module ochc_top #(
    parameter int POR_DELAY_CYC = `OCHC_POR_DELAY_CYC,
    parameter int SS_STEP_CYC = `OCHC_SS_STEP_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // analog comparators and pins, asynchronous
    input wire logic bias_por_ok,
    input wire logic enable_above,
    input wire logic set_reached,
    input wire logic sense_over,
    // internal pwm, same clock
    input wire logic pwm_cycle_tick,
    input wire logic pwm_low_req,
    // gate drive and sample source
    output logic low_gate,
    output logic out_enable,
    output logic sample_current_source,
    // set point and threshold dacs
    output logic [7:0] held_code,
    output logic [8:0] thresh_code,
    output logic ocp_disabled,
    // sequencer status
    output logic [5:0] ss_ref,
    output logic in_regulation,
    output logic hiccup_active,
    output logic trip_pulse,
    output logic monitor_open
);
    localparam logic [19:0] POR_LAST = 20'(POR_DELAY_CYC - 1);
    localparam logic [19:0] STEP_LAST = 20'(SS_STEP_CYC - 1);
    localparam logic [19:0] SAMP_LAST = 20'(`OCHC_SAMPLE_STEP_CYC - 1);
    localparam logic [5:0] BLANK_LAST =
        6'(`OCHC_BLANK_CYC + `OCHC_SYNC_LAG);
    localparam logic [5:0] MINW_LAST = 6'(`OCHC_MIN_LOW_CYC - 1);

    // two-flop synchronisers for the asynchronous inputs
    logic [3:0] async_in;
    logic [3:0] meta_ff;
    logic [3:0] sync_ff;
    assign async_in = {sense_over, set_reached, enable_above, bias_por_ok};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge mclk) begin
                if (reset) begin
                    meta_ff[gi] <= 1'b0;
                    sync_ff[gi] <= 1'b0;
                end else begin
                    meta_ff[gi] <= async_in[gi];
                    sync_ff[gi] <= meta_ff[gi];
                end
            end
        end
    endgenerate
    logic por_ok_s;
    logic enable_s;
    logic set_reached_s;
    logic sense_over_s;
    assign por_ok_s = sync_ff[0];
    assign enable_s = sync_ff[1];
    assign set_reached_s = sync_ff[2];
    assign sense_over_s = sync_ff[3];

    // states in which the power stage may switch
    function automatic logic is_switching(input ochc_pkg::ochc_state_t s);
        return (s == ochc_pkg::ST_SOFT) || (s == ochc_pkg::ST_RUN);
    endfunction : is_switching

    ochc_pkg::ochc_state_t state_ff;
    ochc_pkg::ochc_state_t nxt_state;
    logic [19:0] timer_ff;
    logic [5:0] step_ff;
    logic [7:0] held_ff;
    logic trip;
    logic timer_done;
    logic step_done;
    logic live;

    // power loss or enable below threshold forces shutdown
    assign live = por_ok_s && enable_s;
    assign step_done = (timer_ff == STEP_LAST);
    always_comb begin
        unique case (state_ff)
            ochc_pkg::ST_DELAY:  timer_done = (timer_ff == POR_LAST);
            ochc_pkg::ST_SAMPLE: timer_done = (timer_ff == SAMP_LAST);
            default:             timer_done = step_done;
        endcase
    end

    always_comb begin
        nxt_state = state_ff;
        if (!live) begin
            nxt_state = ochc_pkg::ST_OFF;
        end else begin
            unique case (state_ff)
                ochc_pkg::ST_OFF: nxt_state = ochc_pkg::ST_DELAY;
                ochc_pkg::ST_DELAY: begin
                    if (timer_done) begin
                        nxt_state = ochc_pkg::ST_SAMPLE;
                    end
                end
                ochc_pkg::ST_SAMPLE: begin
                    if (set_reached_s || held_ff == `OCHC_HELD_MAX) begin
                        nxt_state = ochc_pkg::ST_SOFT;
                    end
                end
                ochc_pkg::ST_DUMMY1: begin
                    if (step_done && step_ff == `OCHC_SS_TOP) begin
                        nxt_state = ochc_pkg::ST_DUMMY2;
                    end
                end
                ochc_pkg::ST_DUMMY2: begin
                    if (step_done && step_ff == `OCHC_SS_TOP) begin
                        nxt_state = ochc_pkg::ST_SOFT;
                    end
                end
                ochc_pkg::ST_SOFT: begin
                    if (trip) begin
                        nxt_state = ochc_pkg::ST_DUMMY1;
                    end else if (step_done && step_ff == `OCHC_SS_TOP) begin
                        nxt_state = ochc_pkg::ST_RUN;
                    end
                end
                ochc_pkg::ST_RUN: begin
                    if (trip) begin
                        nxt_state = ochc_pkg::ST_DUMMY1;
                    end
                end
                default: nxt_state = ochc_pkg::ST_OFF;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            state_ff <= ochc_pkg::ST_OFF;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // one timer serves delay, sample steps and ramp steps
    always_ff @(posedge mclk) begin
        if (reset) begin
            timer_ff <= 20'h00000;
        end else if (nxt_state != state_ff || timer_done) begin
            timer_ff <= 20'h00000;
        end else begin
            timer_ff <= timer_ff + 20'h00001;
        end
    end

    // ramp step count, shared by dummy time-outs and the real ramp
    always_ff @(posedge mclk) begin
        if (reset) begin
            step_ff <= 6'h00;
        end else if (nxt_state != state_ff) begin
            step_ff <= 6'h00;
        end else if (step_done && step_ff != `OCHC_SS_TOP) begin
            step_ff <= step_ff + 6'h01;
        end
    end

    // held set point: cleared on power loss and at the end of each delay, redone after shutdown
    always_ff @(posedge mclk) begin
        if (reset || !por_ok_s) begin
            held_ff <= 8'h00;
        end else if (state_ff == ochc_pkg::ST_DELAY && timer_done) begin
            held_ff <= 8'h00;
        end else if (state_ff == ochc_pkg::ST_SAMPLE && timer_done
                     && !set_reached_s && held_ff != `OCHC_HELD_MAX) begin
            held_ff <= held_ff + 8'h01;
        end
    end

    // low gate width tracking and narrow-pulse stretching
    logic req_d_ff;
    logic [5:0] width_ff;
    logic [5:0] blank_ff;
    logic [5:0] stretch_ff;
    logic [1:0] narrow_ff;
    logic wide_seen_ff;
    logic forced_ff;
    logic gate_on;
    logic gate_d_ff;
    logic req_rise;
    assign req_rise = pwm_low_req && !req_d_ff;
    assign gate_on = is_switching(state_ff)
                     && (pwm_low_req || stretch_ff != 6'h00);

    always_ff @(posedge mclk) begin
        if (reset) begin
            req_d_ff <= 1'b0;
            gate_d_ff <= 1'b0;
        end else begin
            req_d_ff <= pwm_low_req;
            gate_d_ff <= gate_on;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            width_ff <= 6'h00;
            wide_seen_ff <= 1'b0;
        end else begin
            if (!gate_on) begin
                width_ff <= 6'h00;
            end else if (width_ff != MINW_LAST) begin
                width_ff <= width_ff + 6'h01;
            end
            // set wins over the cycle-start clear
            if (gate_on && width_ff == MINW_LAST) begin
                wide_seen_ff <= 1'b1;
            end else if (pwm_cycle_tick) begin
                wide_seen_ff <= 1'b0;
            end
        end
    end

    // two narrow cycles in a row force the third
    always_ff @(posedge mclk) begin
        if (reset || !is_switching(state_ff)) begin
            narrow_ff <= 2'h0;
            forced_ff <= 1'b0;
        end else if (pwm_cycle_tick) begin
            if (wide_seen_ff || forced_ff) begin
                narrow_ff <= 2'h0;
            end else if (narrow_ff != `OCHC_NARROW_LIMIT) begin
                narrow_ff <= narrow_ff + 2'h1;
            end
            forced_ff <= !wide_seen_ff && !forced_ff
                         && narrow_ff == 2'h1;
        end
    end

    // forced cycle: pulse inserted at cycle start, stretched on request
    always_ff @(posedge mclk) begin
        if (reset || !is_switching(state_ff)) begin
            stretch_ff <= 6'h00;
        end else if (pwm_cycle_tick && !wide_seen_ff && !forced_ff
                     && narrow_ff == 2'h1) begin
            stretch_ff <= 6'(`OCHC_MIN_LOW_CYC);
        end else if (forced_ff && req_rise) begin
            stretch_ff <= 6'(`OCHC_MIN_LOW_CYC);
        end else if (stretch_ff != 6'h00) begin
            stretch_ff <= stretch_ff - 6'h01;
        end
    end

    // monitoring window after blanking, closed by gate fall
    always_ff @(posedge mclk) begin
        if (reset || !gate_on) begin
            blank_ff <= 6'h00;
        end else if (blank_ff != BLANK_LAST) begin
            blank_ff <= blank_ff + 6'h01;
        end
    end

    logic window;
    logic ocp_off;
    logic [8:0] dbl;
    // blanking padded by the sync lag, so sensed data is past 200ns
    assign window = gate_on && gate_d_ff && blank_ff == BLANK_LAST;
    assign ocp_off = held_ff > `OCHC_OCP_OFF_CODE;
    assign trip = window && sense_over_s && !ocp_off
                  && is_switching(state_ff);
    assign dbl = {held_ff, 1'b0};

    // registered outputs
    always_ff @(posedge mclk) begin
        if (reset) begin
            low_gate <= 1'b0;
            out_enable <= 1'b0;
            sample_current_source <= 1'b0;
            held_code <= 8'h00;
            thresh_code <= 9'h000;
            ocp_disabled <= 1'b0;
            ss_ref <= 6'h00;
            in_regulation <= 1'b0;
            hiccup_active <= 1'b0;
            trip_pulse <= 1'b0;
            monitor_open <= 1'b0;
        end else begin
            low_gate <= gate_on && !trip;
            out_enable <= is_switching(nxt_state);
            // next state, so the source never overlaps switching
            sample_current_source
                <= (nxt_state == ochc_pkg::ST_SAMPLE);
            held_code <= held_ff;
            thresh_code <= (dbl > `OCHC_THRESH_MAX)
                           ? `OCHC_THRESH_MAX : dbl;
            ocp_disabled <= ocp_off;
            ss_ref <= (state_ff == ochc_pkg::ST_RUN) ? `OCHC_SS_TOP
                      : (state_ff == ochc_pkg::ST_SOFT) ? step_ff
                      : 6'h00;
            in_regulation <= (state_ff == ochc_pkg::ST_RUN);
            hiccup_active <= (nxt_state == ochc_pkg::ST_DUMMY1)
                             || (nxt_state == ochc_pkg::ST_DUMMY2);
            trip_pulse <= trip;
            // a trip drops the gate, so the window closes with it
            monitor_open <= window && !trip;
        end
    end
endmodule : ochc_top

// ==== include/ochc_consts.svh ====
// constants for the overcurrent hiccup supervisor
`ifndef OCHC_CONSTS_SVH
`define OCHC_CONSTS_SVH

`define OCHC_CLK_MHZ 100
`define OCHC_POR_DELAY_NS 6800000
`define OCHC_POR_DELAY_CYC ((`OCHC_POR_DELAY_NS * `OCHC_CLK_MHZ) / 1000)
`define OCHC_RAMP_NS 6800000
`define OCHC_SS_STEPS 64
`define OCHC_SS_STEP_CYC \
    ((`OCHC_RAMP_NS * `OCHC_CLK_MHZ) / (1000 * `OCHC_SS_STEPS))
`define OCHC_BLANK_NS 200
`define OCHC_BLANK_CYC ((`OCHC_BLANK_NS * `OCHC_CLK_MHZ) / 1000)
// sensed comparator lags by the synchroniser depth
`define OCHC_SYNC_LAG 2
`define OCHC_MIN_LOW_NS 425
`define OCHC_MIN_LOW_CYC ((`OCHC_MIN_LOW_NS * `OCHC_CLK_MHZ + 999) / 1000)
`define OCHC_SAMPLE_STEP_NS 13300
`define OCHC_SAMPLE_STEP_CYC ((`OCHC_SAMPLE_STEP_NS * `OCHC_CLK_MHZ) / 1000)
`define OCHC_NARROW_LIMIT 2'h2
// held code lsb is 2 mV across the set resistor
`define OCHC_HELD_LSB_MV 2
`define OCHC_HELD_MAX 8'hFF
`define OCHC_OCP_OFF_CODE 8'h96
`define OCHC_THRESH_MAX 9'h0ED
`define OCHC_SS_TOP 6'h3F

`endif

// ==== include/ochc_pkg.sv ====
// types for the overcurrent hiccup supervisor
package ochc_pkg;
    typedef enum logic [2:0] {
        ST_OFF    = 3'h0,
        ST_DELAY  = 3'h1,
        ST_SAMPLE = 3'h2,
        ST_DUMMY1 = 3'h3,
        ST_DUMMY2 = 3'h4,
        ST_SOFT   = 3'h5,
        ST_RUN    = 3'h6
    } ochc_state_t;
endpackage : ochc_pkg

// ==== dv/ochc_monitor.sv ====
// assertion checker for the overcurrent hiccup supervisor
`timescale 1ns/1ps
module ochc_monitor #(
    parameter int SS_STEP_CYC = 20
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset,
    // watched outputs
    input wire logic low_gate,
    input wire logic out_enable,
    input wire logic sample_current_source,
    input wire logic [7:0] held_code,
    input wire logic [8:0] thresh_code,
    input wire logic ocp_disabled,
    input wire logic hiccup_active,
    input wire logic in_regulation,
    input wire logic trip_pulse,
    input wire logic monitor_open
);
    localparam int HIC = 128 * SS_STEP_CYC;
    logic [15:0] gate_cnt_ff;
    // wide enough for the hiccup wait at default ramp timing
    logic [23:0] hic_cnt_ff;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // run lengths of gate-on and of the hiccup wait
    always_ff @(posedge mclk) begin
        if (reset) begin
            gate_cnt_ff <= 16'h0000;
            hic_cnt_ff <= 24'h000000;
        end else begin
            gate_cnt_ff <= low_gate ? gate_cnt_ff + 16'h0001 : 16'h0000;
            hic_cnt_ff <= hiccup_active
                          ? hic_cnt_ff + 24'h000001 : 24'h000000;
        end
    end
    trip_off_a:
        assert property (trip_pulse |-> !out_enable && !low_gate
            && hiccup_active) else $error("output on at trip");
    hic_len_a:
        assert property ($fell(hiccup_active) && out_enable |->
            hic_cnt_ff >= 24'(HIC - 4) && hic_cnt_ff <= 24'(HIC + 4))
            else $error("hiccup wait length");
    no_resample_a:
        assert property (hiccup_active |-> $stable(held_code))
            else $error("set point moved in retry");
    thresh_double_a:
        assert property ($stable(held_code) |-> thresh_code ==
            (held_code > 8'h76 ? 9'h0ED : {held_code, 1'b0}))
            else $error("threshold not doubled");
    ocp_off_a:
        assert property ($stable(held_code) |->
            ocp_disabled == (held_code > 8'h96)) else $error("ocp off");
    sample_quiet_a:
        assert property (sample_current_source |-> !low_gate
            && !out_enable) else $error("gate on while sampling");
    window_gate_a:
        assert property (monitor_open |-> low_gate)
            else $error("window open with gate off");
    blank_time_a:
        assert property (monitor_open |-> gate_cnt_ff >= 16'h0014)
            else $error("window opened too early");
    cover property (trip_pulse);
    cover property ($rose(in_regulation));
    cover property ($rose(monitor_open));
endmodule : ochc_monitor

bind ochc_top ochc_monitor #(.SS_STEP_CYC(SS_STEP_CYC)) i_mon (
    .mclk(mclk), .reset(reset), .low_gate(low_gate),
    .out_enable(out_enable), .sample_current_source(sample_current_source),
    .held_code(held_code), .thresh_code(thresh_code),
    .ocp_disabled(ocp_disabled), .hiccup_active(hiccup_active),
    .in_regulation(in_regulation), .trip_pulse(trip_pulse),
    .monitor_open(monitor_open));

// ==== dv/ochc_stage_model.sv ====
// switching stage and set resistor model facing the supervisor
`timescale 1ns/1ps
module ochc_stage_model #(
    parameter int PERIOD = 167
) (
    // clock and scenario controls
    input wire logic mclk,
    input wire logic short_on,
    input wire logic [7:0] set_code,
    input wire logic [7:0] low_wid,
    // supervisor outputs
    input wire logic low_gate,
    input wire logic [7:0] held_code,
    // comparators and pwm into the supervisor
    output logic set_reached,
    output logic sense_over,
    output logic pwm_cycle_tick,
    output logic pwm_low_req
);
    logic [7:0] ph_ff = 8'h00;
    assign set_reached = held_code >= set_code;
    // a short pulls the drop over any threshold while the gate is on
    assign sense_over = short_on & low_gate;
    initial begin
        pwm_cycle_tick = 1'b0;
        pwm_low_req = 1'b0;
    end
    // pwm moves just after the edge, like every bench input
    always @(posedge mclk) begin
        ph_ff <= (ph_ff == 8'(PERIOD - 1)) ? 8'h00 : ph_ff + 8'h01;
        #1;
        pwm_cycle_tick = ph_ff == 8'h00;
        pwm_low_req = ph_ff < low_wid;
    end
endmodule : ochc_stage_model

// ==== dv/ochc_top_bench.sv ====
// self-checking bench for the overcurrent hiccup supervisor
`timescale 1ns/1ps
module ochc_top_bench;
    localparam int SS = 20;
    localparam int POR = 50;
    localparam int HIC = 128 * SS;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic bias_por_ok = 1'b0;
    logic enable_above = 1'b0;
    logic short_on = 1'b0;
    logic [7:0] set_code = 8'h04;
    logic [7:0] low_wid = 8'h64;
    logic set_reached, sense_over, pwm_cycle_tick, pwm_low_req;
    logic low_gate, out_enable, sample_current_source, ocp_disabled;
    logic in_regulation, hiccup_active, trip_pulse, monitor_open;
    logic [7:0] held_code;
    logic [8:0] thresh_code;
    logic [5:0] ss_ref;
    int n_fail = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #5 mclk = ~mclk;
    ochc_top #(.POR_DELAY_CYC(POR), .SS_STEP_CYC(SS)) i_dut (
        .mclk(mclk), .reset(reset), .bias_por_ok(bias_por_ok),
        .enable_above(enable_above), .set_reached(set_reached),
        .sense_over(sense_over), .pwm_cycle_tick(pwm_cycle_tick),
        .pwm_low_req(pwm_low_req), .low_gate(low_gate),
        .out_enable(out_enable),
        .sample_current_source(sample_current_source),
        .held_code(held_code), .thresh_code(thresh_code),
        .ocp_disabled(ocp_disabled), .ss_ref(ss_ref),
        .in_regulation(in_regulation), .hiccup_active(hiccup_active),
        .trip_pulse(trip_pulse), .monitor_open(monitor_open));
    ochc_stage_model i_stage (
        .mclk(mclk), .short_on(short_on), .set_code(set_code),
        .low_wid(low_wid), .low_gate(low_gate), .held_code(held_code),
        .set_reached(set_reached), .sense_over(sense_over),
        .pwm_cycle_tick(pwm_cycle_tick), .pwm_low_req(pwm_low_req));
    task automatic test_done();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge mclk);
            #1;
        end
    endtask : cyc
    function automatic logic sig(input int s);
        case (s)
            0: return sample_current_source;
            1: return in_regulation;
            2: return trip_pulse;
            default: return out_enable;
        endcase
    endfunction : sig
    // bounded wait on one status output, then confirm it arrived
    task automatic wt(input int s, input logic v, input int lim,
                      output int n);
        n = 0;
        while (sig(s) !== v && n < lim) begin
            cyc(1);
            n++;
        end
        chk(16'(sig(s)), 16'(v));
    endtask : wt
    task automatic t_startup();
        int n;
        // pin held low for 20 cycles with the bias supply already up
        cyc(20);
        chk(16'(sample_current_source), 16'h0000);
        enable_above = 1'b1;
        wt(0, 1'b1, POR + 10, n);
        chk(16'(n >= POR && n <= POR + 6), 16'h0001);
        chk(16'(low_gate), 16'h0000);
        wt(0, 1'b0, 6000, n);
        chk(16'(held_code), 16'(set_code));
        chk(16'(thresh_code), 16'({set_code, 1'b0}));
        wt(1, 1'b1, 64 * SS + 40, n);
        chk(16'(ss_ref), 16'h003F);
    endtask : t_startup
    task automatic t_stretch();
        int w;
        int wmax;
        low_wid = 8'h05;
        w = 0;
        wmax = 0;
        repeat (4 * 167) begin
            cyc(1);
            w = low_gate ? w + 1 : 0;
            if (w > wmax) wmax = w;
        end
        chk(16'(wmax >= 43 && wmax <= 48), 16'h0001);
        low_wid = 8'h64;
    endtask : t_stretch
    task automatic t_hiccup();
        int n;
        int m;
        short_on = 1'b1;
        wt(2, 1'b1, 400, n);
        wt(3, 1'b1, HIC + 20, n);
        chk(16'(n >= HIC - 4 && n <= HIC + 4), 16'h0001);
        wt(2, 1'b1, 64 * SS, m);
        chk(16'(n + m >= HIC && n + m <= HIC + 64 * SS + 8), 16'h0001);
        wt(3, 1'b1, HIC + 20, n);
        chk(16'(held_code), 16'(set_code));
        short_on = 1'b0;
        wt(1, 1'b1, 64 * SS + 40, n);
    endtask : t_hiccup
    task automatic t_shutdown();
        int n;
        enable_above = 1'b0;
        wt(3, 1'b0, 6, n);
        set_code = 8'h06;
        cyc(10);
        enable_above = 1'b1;
        wt(0, 1'b1, POR + 10, n);
        wt(0, 1'b0, 9000, n);
        chk(16'(held_code), 16'h0006);
        wt(1, 1'b1, 64 * SS + 40, n);
    endtask : t_shutdown
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            test_done();
        end
    end
    initial begin
        repeat (8) @(posedge mclk);
        #1;
        reset = 1'b0;
        bias_por_ok = 1'b1;
        t_startup();
        t_stretch();
        t_hiccup();
        t_shutdown();
        test_done();
    end
endmodule : ochc_top_bench
